/* inc/ddrbw_defines.svh */
`ifndef DDRBW_DEFINES_SVH
`define DDRBW_DEFINES_SVH

// Default data word width: one of 8, 9, 18, 36
`define DDRBW_DATA_W        18
// Default width of the latched burst address
`define DDRBW_ADDR_W        8
// Words held between the capture stage and the array
`define DDRBW_FIFO_DEPTH    8
// Bits governed by one select in the 8-bit build
`define DDRBW_NIBBLE_BITS   4
// Bits governed by one select in the 9, 18 and 36-bit builds
`define DDRBW_BYTE_BITS     9
// Burst word offsets
`define DDRBW_BURST_FIRST   1'h0
`define DDRBW_BURST_SECOND  1'h1
// Reset values of the data pins
`define DDRBW_DQ_RESET      1'h0
`define DDRBW_OE_N_RESET    1'h1

`endif

/* inc/ddrbw_pkg.sv */
package ddrbw_pkg;

    // Operation decoded at a true-clock rise
    typedef enum logic [1:0] {
        DDRBW_NOP,
        DDRBW_READ,
        DDRBW_WRITE
    } ddrbw_op_e;

endpackage : ddrbw_pkg

/* hw/ddrbw_fifo.sv */
`include "ddrbw_defines.svh"

module ddrbw_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = `DDRBW_FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad_cfg
            $error("ddrbw_fifo: DEPTH must be at least 2 and WIDTH at least 1");
        end
    endgenerate

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    wire [PTR_W-1:0] next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    wire [PTR_W-1:0] next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

    assign in_ready_o  = (count != CNT_W'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = store[rd_ptr];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= next_wr_ptr;
            end
            if (pop) begin
                rd_ptr <= next_rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            store[wr_ptr] <= in_data_i;
        end
    end

endmodule : ddrbw_fifo

/* hw/ddrbw_mem.sv */
module ddrbw_mem #(
    parameter int WIDTH  = 18,
    parameter int ADDR_W = 9
) (
    input  wire logic              clk_i,
    input  wire logic              wr_en_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [WIDTH-1:0]  wr_data_i,
    input  wire logic [WIDTH-1:0]  wr_bit_en_i,
    input  wire logic              rd_en_i,
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic      [WIDTH-1:0]  rd_data_o
);

    generate
        if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_cfg
            $error("ddrbw_mem: ADDR_W must lie between 1 and 24");
        end
    endgenerate

    logic [WIDTH-1:0] array [2**ADDR_W];

    // Bits whose enable is low keep their stored value
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (wr_bit_en_i[i]) begin
                    array[wr_addr_i][i] <= wr_data_i[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rd_en_i) begin
            rd_data_o <= array[rd_addr_i];
        end
    end

endmodule : ddrbw_mem

/* hw/ddrbw_top.sv */
// Summary of operation
// RULE1 - Load low, direction low starts write
// RULE2 - Write words at t+1 true, inverted rises
// RULE3 - Read words driven at t+2 rises
// RULE4 - Load high means no operation, tristate
// RULE5 - Capture data and selects on both rises
// RULE6 - Read data delivered on both rises
// RULE7 - 18-bit: both selects low write all
// RULE8 - 18-bit: select0 low writes bits 8:0
// RULE9 - 18-bit: select1 low writes bits 17:9
// RULE10 - 8-bit: select0 low writes bits 3:0
// RULE11 - 8-bit: select1 low writes 7:4
// RULE12 - 8/18-bit: both high write nothing
// RULE13 - 9-bit: select low writes nine bits
// RULE14 - 9/36-bit: all high write nothing
// RULE15 - 36-bit: all low write whole word
// RULE16 - 36-bit: select0 low writes 8:0
// RULE17 - 36-bit: select1 low writes 17:9
// RULE18 - 36-bit: select2 low writes 26:18
// RULE19 - 36-bit: select3 low writes 35:27
// RULE20 - Each portion uses its own selects
// RULE21 - Deselected and tristate after reset
// RULE22 - Second word goes to A plus 1
// RULE23 - Cycle t is the start cycle
// RULE24 - Stopped clocks best left both high
// RULE25 - Width parameter sets lanes and ranges
`include "ddrbw_defines.svh"

module ddrbw_top #(
    parameter int DATA_W     = `DDRBW_DATA_W,
    parameter int ADDR_W     = `DDRBW_ADDR_W,
    parameter int FIFO_DEPTH = `DDRBW_FIFO_DEPTH,
    localparam int LANE_BITS = (DATA_W == 8) ? `DDRBW_NIBBLE_BITS : `DDRBW_BYTE_BITS,
    localparam int NLANE     = DATA_W / LANE_BITS
) (
    input  wire logic              MCLK_I,
    input  wire logic              RSTN_I,
    input  wire logic              K_RISE_I,
    input  wire logic              KN_RISE_I,
    input  wire logic              LOAD_STROBE_N_I,
    input  wire logic              READ_NWRITE_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] DATA_I,
    input  wire logic [NLANE-1:0]  LANE_WRITE_SELECT_N_I,
    output logic      [DATA_W-1:0] DQ_O,
    output logic                   DQ_OE_N_O,
    output logic                   WBUF_READY_O
);

    // Only the documented widths are served
    generate
        if (DATA_W != 8 && DATA_W != 9 && DATA_W != 18 && DATA_W != 36) begin : g_bad_w
            $error("ddrbw_top: DATA_W must be 8, 9, 18 or 36");
        end
        if (FIFO_DEPTH < 2) begin : g_bad_d
            $error("ddrbw_top: FIFO_DEPTH must be at least 2");
        end
    endgenerate

    localparam int WADDR_W = ADDR_W + 1;
    localparam int WORD_W  = WADDR_W + 2 * DATA_W;

    // Selects are active low; each governs LANE_BITS contiguous bits
    function automatic logic [DATA_W-1:0] lane_bit_mask(
        input logic [NLANE-1:0] sel_n
    );
        logic [DATA_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < DATA_W; i++) begin
            mask[i] = ~sel_n[i / LANE_BITS]; // RULE7 RULE8 RULE9 RULE10 RULE11 RULE13 RULE15 RULE16 RULE17 RULE18 RULE19 RULE25
        end
        return mask;
    endfunction : lane_bit_mask

    // Decode at a true-clock rise
    ddrbw_pkg::ddrbw_op_e op;
    assign op = (!K_RISE_I || LOAD_STROBE_N_I) ? ddrbw_pkg::DDRBW_NOP : // RULE4
                READ_NWRITE_I ? ddrbw_pkg::DDRBW_READ :
                                ddrbw_pkg::DDRBW_WRITE; // RULE1

    wire start_wr = (op == ddrbw_pkg::DDRBW_WRITE);
    wire start_rd = (op == ddrbw_pkg::DDRBW_READ);

    // Write pipeline: stage 1 spans cycle t+1 up to its true rise,
    // stage 2 covers the inverted rise of t+1
    logic              wr_s1;
    logic              wr_s2;
    logic [ADDR_W-1:0] wr_a1;
    logic [ADDR_W-1:0] wr_a2;

    // Read pipeline, one stage per true-clock rise
    logic              rd_s1;
    logic              rd_s2;
    logic              rd_s3;
    logic [ADDR_W-1:0] rd_a1;
    logic [ADDR_W-1:0] rd_a2;
    logic [ADDR_W-1:0] rd_a3;

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_s1 <= 1'h0;
            wr_s2 <= 1'h0;
            wr_a1 <= '0;
            wr_a2 <= '0;
        end else if (K_RISE_I) begin
            wr_s1 <= start_wr; // RULE1 RULE23
            wr_a1 <= ADDR_I;
            wr_s2 <= wr_s1;
            wr_a2 <= wr_a1;
        end
    end

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rd_s1 <= 1'h0;
            rd_s2 <= 1'h0;
            rd_s3 <= 1'h0;
            rd_a1 <= '0;
            rd_a2 <= '0;
            rd_a3 <= '0;
        end else if (K_RISE_I) begin
            rd_s1 <= start_rd; // RULE23
            rd_a1 <= ADDR_I;
            rd_s2 <= rd_s1;
            rd_a2 <= rd_a1;
            rd_s3 <= rd_s2;
            rd_a3 <= rd_a2;
        end
    end

    // Data portions: first word at the true rise of t+1, second at the
    // inverted rise that follows, each with the selects sampled with it
    wire               take_first  = K_RISE_I & wr_s1; // RULE2
    wire               take_second = KN_RISE_I & wr_s2; // RULE2
    wire [DATA_W-1:0]  cap_mask    = lane_bit_mask(LANE_WRITE_SELECT_N_I); // RULE20
    wire               cap_any     = |cap_mask;
    wire [WADDR_W-1:0] cap_addr    = take_first ? {wr_a1, `DDRBW_BURST_FIRST} :
                                                  {wr_a2, `DDRBW_BURST_SECOND}; // RULE22

    logic              push_valid;
    logic [WORD_W-1:0] push_word;
    wire               push_ready;

    // A portion with every select high is dropped here and never
    // reaches the array
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            push_valid <= 1'h0;
            push_word  <= '0;
        end else begin
            push_valid <= (take_first | take_second) & cap_any; // RULE5 RULE12 RULE14
            push_word  <= {cap_addr, DATA_I, cap_mask}; // RULE5
        end
    end

    // Array read port: first word fetched on the inverted rise of t+1,
    // second word on the true rise of t+2
    wire               rd_first   = KN_RISE_I & rd_s2;
    wire               rd_second  = K_RISE_I & rd_s2;
    wire               mem_rd_en  = rd_first | rd_second;
    wire [WADDR_W-1:0] mem_rd_adr = rd_first ? {rd_a2, `DDRBW_BURST_FIRST} :
                                               {rd_a2, `DDRBW_BURST_SECOND}; // RULE22
    wire [DATA_W-1:0]  mem_rd_dat;

    // Reads own the array in their cycles, so the buffer stalls then
    wire               pop_valid;
    wire [WORD_W-1:0]  pop_word;
    wire               pop_ready  = ~mem_rd_en;
    wire               mem_wr_en  = pop_valid & pop_ready;

    wire [WADDR_W-1:0] mem_wr_adr = pop_word[WORD_W-1 -: WADDR_W];
    wire [DATA_W-1:0]  mem_wr_dat = pop_word[2*DATA_W-1 -: DATA_W];
    wire [DATA_W-1:0]  mem_wr_msk = pop_word[DATA_W-1:0];

    ddrbw_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (MCLK_I),
        .rstn_i      (RSTN_I),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_word),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pop_word)
    );

    ddrbw_mem #(
        .WIDTH  (DATA_W),
        .ADDR_W (WADDR_W)
    ) u_mem (
        .clk_i       (MCLK_I),
        .wr_en_i     (mem_wr_en),
        .wr_addr_i   (mem_wr_adr),
        .wr_data_i   (mem_wr_dat),
        .wr_bit_en_i (mem_wr_msk),
        .rd_en_i     (mem_rd_en),
        .rd_addr_i   (mem_rd_adr),
        .rd_data_o   (mem_rd_dat)
    );

    // Output drive: the true rise of t+2 loads the first word, the
    // inverted rise after it the second; a true rise with no read due
    // releases the pins
    wire drive_first  = K_RISE_I & rd_s2; // RULE3 RULE6
    wire drive_second = KN_RISE_I & rd_s3; // RULE3 RULE6

    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            DQ_O      <= {DATA_W{`DDRBW_DQ_RESET}};
            DQ_OE_N_O <= `DDRBW_OE_N_RESET; // RULE21
        end else begin
            if (drive_first || drive_second) begin
                DQ_O <= mem_rd_dat; // RULE6
            end
            if (K_RISE_I) begin
                DQ_OE_N_O <= ~rd_s2; // RULE4 RULE21
            end
        end
    end

    // Space in the write buffer, so a controller can hold off writes
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            WBUF_READY_O <= 1'h1;
        end else begin
            WBUF_READY_O <= push_ready;
        end
    end

endmodule : ddrbw_top

/* verif/ddrbw_checker.sv */
module ddrbw_checker #(
    parameter int DATA_W = 18
) (
    input wire logic              MCLK_I,
    input wire logic              RSTN_I,
    input wire logic              K_RISE_I,
    input wire logic              LOAD_STROBE_N_I,
    input wire logic              READ_NWRITE_I,
    input wire logic [DATA_W-1:0] DQ_O,
    input wire logic              DQ_OE_N_O,
    input wire logic              WBUF_READY_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_take;
    assign rd_take = K_RISE_I && !LOAD_STROBE_N_I && READ_NWRITE_I;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    property p_reset_state;
        $rose(RSTN_I) |-> DQ_OE_N_O && WBUF_READY_O && DQ_O == '0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
    property p_read_oe;
        rd_take |-> ##5 !DQ_OE_N_O ##1 !DQ_OE_N_O;
    endproperty
    a_read_oe: assert property (p_read_oe) else $error("read not driven");
    property p_nop_hiz;
        K_RISE_I && !rd_take |-> ##5 DQ_OE_N_O;
    endproperty
    a_nop_hiz: assert property (p_nop_hiz) else $error("driven without read");
    property p_oe_on_k;
        $changed(DQ_OE_N_O) |-> $past(K_RISE_I);
    endproperty
    a_oe_on_k: assert property (p_oe_on_k) else $error("enable moved off K");
    property p_oe_fall_cause;
        $fell(DQ_OE_N_O) |-> $past(rd_take, 5);
    endproperty
    a_oe_fall_cause: assert property (p_oe_fall_cause) else $error("early drive");
    property p_dq_only_reading;
        $changed(DQ_O) |-> !DQ_OE_N_O;
    endproperty
    a_dq_only_reading: assert property (p_dq_only_reading) else $error("data moved");
    property p_nop_stable;
        K_RISE_I && !rd_take |-> ##5 $stable(DQ_O) ##1 $stable(DQ_O);
    endproperty
    a_nop_stable: assert property (p_nop_stable) else $error("data moved on nop");
    property p_oe_rise_cause;
        $rose(DQ_OE_N_O) |-> $past(K_RISE_I) && !$past(rd_take, 5);
    endproperty
    a_oe_rise_cause: assert property (p_oe_rise_cause) else $error("early release");
endmodule : ddrbw_checker

/* verif/ddrbw_ctrl_model.sv */
module ddrbw_ctrl_model (
    input  wire logic   clk_i,
    input  wire logic   rstn_i,
    output logic        k_rise_o,
    output logic        kn_rise_o,
    output logic        load_n_o,
    output logic        rnw_o,
    output logic [7:0]  addr_o,
    output logic [17:0] data_o,
    output logic [1:0]  sel_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {k_rise_o, kn_rise_o, rnw_o, addr_o, data_o} = '0;
        {load_n_o, sel_n_o} = 3'h7;
    end
    // True and inverted rises alternate, one system clock each; in
    // reset no rises come, as with both clocks stopped high
    always @(negedge clk_i) begin
        k_rise_o  <= rstn_i && !k_rise_o;
        kn_rise_o <= rstn_i && k_rise_o;
    end
    task automatic op(input logic rnw, input logic [7:0] a);
        // An inverted-rise cycle ending here means a true rise comes next
        do begin
            @(negedge clk_i);
        end while (kn_rise_o !== 1'h1);
        load_n_o = 1'h0;
        rnw_o    = rnw;
        addr_o   = a;
        @(negedge clk_i);
        load_n_o = 1'h1;
        addr_o   = ~a;
    endtask : op
    // One data portion a call, selects travel with their own word
    task automatic put(input logic [17:0] d, input logic [1:0] s);
        @(negedge clk_i);
        data_o  = d;
        sel_n_o = s;
    endtask : put
    task automatic idle(input logic rnw, input int n);
        rnw_o = rnw;
        repeat (n) @(negedge clk_i);
    endtask : idle
endmodule : ddrbw_ctrl_model

/* verif/ddrbw_sram_byte_write_bench.sv */
module ddrbw_sram_byte_write_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk;
    logic        rstn;
    logic        k_rise;
    logic        kn_rise;
    logic        load_n;
    logic        rnw;
    logic [7:0]  addr;
    logic [17:0] data;
    logic [1:0]  sel_n;
    logic [17:0] dq;
    logic [35:0] dq36;
    logic [8:0]  dq9;
    logic [7:0]  dq8;
    logic        dq_oe_n;
    logic        wbuf_ready;
    logic [17:0] m0;
    logic [17:0] m1;
    int          n_mismatch = 0;
    int          num_checks = 0;
    ddrbw_top #(.DATA_W(18), .ADDR_W(8), .FIFO_DEPTH(8)) u_dut (
        .MCLK_I(mclk), .RSTN_I(rstn), .K_RISE_I(k_rise), .KN_RISE_I(kn_rise),
        .LOAD_STROBE_N_I(load_n), .READ_NWRITE_I(rnw), .ADDR_I(addr), .DATA_I(data),
        .LANE_WRITE_SELECT_N_I(sel_n), .DQ_O(dq), .DQ_OE_N_O(dq_oe_n),
        .WBUF_READY_O(wbuf_ready));
    // Other widths see the same traffic with lanes copied from the 18-bit word
    ddrbw_top #(.DATA_W(36), .ADDR_W(8), .FIFO_DEPTH(8)) u_dut_w36 (
        .MCLK_I(mclk), .RSTN_I(rstn), .K_RISE_I(k_rise), .KN_RISE_I(kn_rise),
        .LOAD_STROBE_N_I(load_n), .READ_NWRITE_I(rnw), .ADDR_I(addr), .DATA_I({data, data}),
        .LANE_WRITE_SELECT_N_I({sel_n, sel_n}), .DQ_O(dq36), .DQ_OE_N_O(),
        .WBUF_READY_O());
    ddrbw_top #(.DATA_W(9), .ADDR_W(8), .FIFO_DEPTH(8)) u_dut_w9 (
        .MCLK_I(mclk), .RSTN_I(rstn), .K_RISE_I(k_rise), .KN_RISE_I(kn_rise),
        .LOAD_STROBE_N_I(load_n), .READ_NWRITE_I(rnw), .ADDR_I(addr), .DATA_I(data[8:0]),
        .LANE_WRITE_SELECT_N_I(sel_n[0]), .DQ_O(dq9), .DQ_OE_N_O(),
        .WBUF_READY_O());
    ddrbw_top #(.DATA_W(8), .ADDR_W(8), .FIFO_DEPTH(8)) u_dut_w8 (
        .MCLK_I(mclk), .RSTN_I(rstn), .K_RISE_I(k_rise), .KN_RISE_I(kn_rise),
        .LOAD_STROBE_N_I(load_n), .READ_NWRITE_I(rnw), .ADDR_I(addr),
        .DATA_I({data[12:9], data[3:0]}), .LANE_WRITE_SELECT_N_I(sel_n), .DQ_O(dq8),
        .DQ_OE_N_O(), .WBUF_READY_O());
    ddrbw_ctrl_model u_ctrl (
        .clk_i(mclk), .rstn_i(rstn), .k_rise_o(k_rise), .kn_rise_o(kn_rise),
        .load_n_o(load_n), .rnw_o(rnw), .addr_o(addr), .data_o(data), .sel_n_o(sel_n));
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Low select opens its nine-bit lane
    function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n,
                                          input logic [1:0] s);
        return (o & ~{{9{!s[1]}}, {9{!s[0]}}}) | (n & {{9{!s[1]}}, {9{!s[0]}}});
    endfunction : merge
    task automatic wr(input logic [17:0] d0, input logic [1:0] s0,
                      input logic [17:0] d1, input logic [1:0] s1);
        u_ctrl.op(1'h0, 8'h5a);
        u_ctrl.put(d0, s0);
        u_ctrl.put(d1, s1);
        u_ctrl.put(~d1, 2'h3);
        m0 = merge(m0, d0, s0);
        m1 = merge(m1, d1, s1);
        u_ctrl.idle(1'h0, 8);
    endtask : wr
    task automatic rd;
        u_ctrl.op(1'h1, 8'h5a);
        repeat (3) @(negedge mclk);
        check({17'h0, dq_oe_n}, 18'h1);
        @(negedge mclk);
        check({17'h0, dq_oe_n}, 18'h0);
        check(dq, m0);
        check(dq36[35:18], m0);
        check(dq36[17:0], m0);
        check({9'h0, dq9}, {9'h0, m0[8:0]});
        check({10'h0, dq8}, {10'h0, m0[12:9], m0[3:0]});
        @(negedge mclk);
        check(dq, m1);
        check(dq36[35:18], m1);
        check(dq36[17:0], m1);
        check({9'h0, dq9}, {9'h0, m1[8:0]});
        check({10'h0, dq8}, {10'h0, m1[12:9], m1[3:0]});
        @(negedge mclk);
        check({17'h0, dq_oe_n}, 18'h1);
        u_ctrl.idle(1'h0, 2);
    endtask : rd
    task automatic t_reset;
        check({16'h0, dq_oe_n, wbuf_ready}, 18'h3);
        check(dq, 18'h0);
    endtask : t_reset
    task automatic t_full;
        wr(18'h2c3a5, 2'h0, 18'h13c5a, 2'h0);
        rd();
    endtask : t_full
    task automatic t_lanes;
        for (int s = 0; s < 4; s++) begin
            wr(18'h0f0f0 ^ 18'(s * 18'h11111), 2'(s), 18'h3cccc ^ 18'(s), 2'(3 - s));
            rd();
        end
    endtask : t_lanes
    task automatic t_nop;
        u_ctrl.idle(1'h1, 12);
        check({17'h0, dq_oe_n}, 18'h1);
        check(dq, m1);
        check({17'h0, wbuf_ready}, 18'h1);
    endtask : t_nop
    task automatic t_midreset;
        rstn = 1'h0;
        @(negedge mclk);
        t_reset();
        rstn = 1'h1;
    endtask : t_midreset
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        rstn = 1'h0;
        repeat (20) @(negedge mclk);
        t_reset();
        rstn = 1'h1;
        t_full();
        t_lanes();
        t_nop();
        t_midreset();
        t_full();
        wrap_up();
    end
    // About 200 clocks of traffic; five times that means a hang
    initial begin
        #4000;
        n_mismatch++;
        wrap_up();
    end
endmodule : ddrbw_sram_byte_write_bench
bind ddrbw_top ddrbw_checker #(.DATA_W(DATA_W)) u_chk (
    .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .K_RISE_I(K_RISE_I), .LOAD_STROBE_N_I(LOAD_STROBE_N_I),
    .READ_NWRITE_I(READ_NWRITE_I), .DQ_O(DQ_O), .DQ_OE_N_O(DQ_OE_N_O),
    .WBUF_READY_O(WBUF_READY_O));
